//--- logic/srw_pkg.sv
// constants and types for the supervisor reset and watchdog block
package srw_pkg;

  // timebase and durations
  localparam int unsigned CLK_KHZ          = 40000;
  localparam int unsigned RESET_PULSE_MS   = 200;
  localparam int unsigned MIN_PULSE_MS     = 140;
  localparam int unsigned WD_PERIOD_MS     = 1600;
  localparam int unsigned RESET_PULSE_CYC  = RESET_PULSE_MS * CLK_KHZ;
  localparam int unsigned MIN_PULSE_CYC    = MIN_PULSE_MS * CLK_KHZ;
  localparam int unsigned WD_PERIOD_CYC    = WD_PERIOD_MS * CLK_KHZ;

  // output set options
  localparam logic [1:0]  OUTSET_LOW_ONLY  = 2'h0;
  localparam logic [1:0]  OUTSET_BOTH      = 2'h1;
  localparam logic [1:0]  OUTSET_HIGH_ONLY = 2'h2;

  // synchroniser bit positions and reset levels
  localparam int unsigned SYNC_W           = 5;
  localparam int unsigned SYNC_SUPPLY      = 0;
  localparam int unsigned SYNC_PFAIL       = 1;
  localparam int unsigned SYNC_FLOAT       = 2;
  localparam int unsigned SYNC_KICK        = 3;
  localparam int unsigned SYNC_MANUAL      = 4;
  localparam logic [4:0]  SYNC_RST_VAL     = 5'h10;

  // output reset values
  localparam logic        RST_OUT_N_INIT   = 1'h0;
  localparam logic        WD_OUT_N_INIT    = 1'h1;
  localparam logic        PF_N_INIT        = 1'h1;

  typedef enum logic [2:0]
  {
    RST_HOLD    = 3'h1,
    RST_STRETCH = 3'h2,
    RST_RUN     = 3'h4
  } srw_rst_state_type;

endpackage

//--- logic/srw_top.sv
// supervisor: reset stretcher, watchdog timer and power fail flag
`timescale 1ns/1ps
module srw_top
#(
  parameter logic [1:0]  OUT_SET    = srw_pkg::OUTSET_LOW_ONLY,
  parameter int unsigned RST_CYCLES = srw_pkg::RESET_PULSE_CYC,
  parameter int unsigned WD_CYCLES  = srw_pkg::WD_PERIOD_CYC
)
(
  // clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  // comparator and detector results
  input  wire logic supply_low_in,
  input  wire logic power_fail_sense_in,
  input  wire logic kick_float_in,
  // processor side pins
  input  wire logic watchdog_kick_in,
  input  wire logic manual_reset_n,
  // outputs
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      watchdog_expired_n,
  output logic      power_fail_flag_n
);
  import srw_pkg::*;

  localparam int unsigned RCW     = $clog2(RST_CYCLES + 1);
  localparam int unsigned WCW     = $clog2(WD_CYCLES + 1);
  localparam logic [RCW-1:0] RST_LAST = RCW'(RST_CYCLES - 1);
  localparam logic [WCW-1:0] WD_LAST  = WCW'(WD_CYCLES - 1);
  // variants with both polarities carry no watchdog
  localparam bit HAS_WD  = (OUT_SET != OUTSET_BOTH);
  localparam bit HAS_LOW = (OUT_SET != OUTSET_HIGH_ONLY);
  localparam bit HAS_HI  = (OUT_SET != OUTSET_LOW_ONLY);

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_s1_r;
  logic [SYNC_W-1:0] sync_s2_r;
  logic              kick_d_r;
  logic              supply_low_s;
  logic              pfail_s;
  logic              float_s;
  logic              kick_s;
  logic              manual_n_s;
  logic              cause;
  logic              kick_edge;
  srw_rst_state_type state_r;
  srw_rst_state_type state_nxt;
  logic [RCW-1:0]    rs_cnt_r;
  logic [RCW-1:0]    rs_cnt_nxt;
  logic              run_nxt;
  logic              wd_en;
  logic              wd_clear;
  logic              wd_at_last;
  logic [WCW-1:0]    wd_cnt_r;
  logic [WCW-1:0]    wd_cnt_nxt;
  logic              expired_r;
  logic              expired_nxt;
  logic              wd_out_n_nxt;

  // two-flop synchronisers for all asynchronous inputs
  assign sync_raw = {manual_reset_n, watchdog_kick_in, kick_float_in,
                     power_fail_sense_in, supply_low_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          sync_s1_r[gi] <= SYNC_RST_VAL[gi];
          sync_s2_r[gi] <= SYNC_RST_VAL[gi];
        end
        else if (clk_en)
        begin
          sync_s1_r[gi] <= sync_raw[gi];
          sync_s2_r[gi] <= sync_s1_r[gi];
        end
      end
    end
  endgenerate

  assign supply_low_s = sync_s2_r[SYNC_SUPPLY];
  assign pfail_s      = sync_s2_r[SYNC_PFAIL];
  assign float_s      = sync_s2_r[SYNC_FLOAT];
  assign kick_s       = sync_s2_r[SYNC_KICK];
  assign manual_n_s   = sync_s2_r[SYNC_MANUAL];

  // manual reset low asserts reset; supply low holds it
  assign cause     = supply_low_s | ~manual_n_s;
  // both edges of the kick input count as activity
  assign kick_edge = kick_s ^ kick_d_r;

  // reset sequencer; bounce on manual reset simply restarts the stretch
  always_comb
  begin
    state_nxt  = state_r;
    rs_cnt_nxt = rs_cnt_r;
    case (state_r)
      RST_HOLD:
      begin
        rs_cnt_nxt = '0;
        if (!cause)
          state_nxt = RST_STRETCH;
      end
      RST_STRETCH:
      begin
        if (cause)
        begin
          state_nxt  = RST_HOLD;
          rs_cnt_nxt = '0;
        end
        else if (rs_cnt_r == RST_LAST)
        begin
          state_nxt  = RST_RUN;
          rs_cnt_nxt = '0;
        end
        else
          rs_cnt_nxt = rs_cnt_r + RCW'(1);
      end
      RST_RUN:
      begin
        rs_cnt_nxt = '0;
        // only supply low or manual reset can end normal running
        if (cause)
          state_nxt = RST_HOLD;
      end
      default:
      begin
        state_nxt  = RST_HOLD;
        rs_cnt_nxt = '0;
      end
    endcase
  end

  assign run_nxt = (state_nxt == RST_RUN);

  // watchdog timer
  assign wd_en       = HAS_WD && (state_r == RST_RUN) && !float_s;
  assign wd_clear    = !wd_en || kick_edge;
  assign wd_at_last  = (wd_cnt_r == WD_LAST);
  assign wd_cnt_nxt  = wd_clear ? '0 :
                       (wd_at_last ? wd_cnt_r : wd_cnt_r + WCW'(1));
  assign expired_nxt  = wd_clear ? 1'h0 : (expired_r || wd_at_last);
  assign wd_out_n_nxt = HAS_WD ? !(expired_nxt || supply_low_s) : 1'h1;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r  <= RST_HOLD;
      rs_cnt_r <= '0;
      kick_d_r <= 1'h0;
      wd_cnt_r <= '0;
      expired_r <= 1'h0;
    end
    else if (clk_en)
    begin
      state_r   <= state_nxt;
      rs_cnt_r  <= rs_cnt_nxt;
      kick_d_r  <= kick_s;
      wd_cnt_r  <= wd_cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  // registered outputs; absent outputs rest inactive
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reset_out_n        <= HAS_LOW ? RST_OUT_N_INIT : 1'h1;
      reset_out          <= HAS_HI ? ~RST_OUT_N_INIT : 1'h0;
      watchdog_expired_n <= WD_OUT_N_INIT;
      power_fail_flag_n  <= PF_N_INIT;
    end
    else if (clk_en)
    begin
      reset_out_n        <= HAS_LOW ? run_nxt : 1'h1;
      reset_out          <= HAS_HI ? !run_nxt : 1'h0;
      watchdog_expired_n <= wd_out_n_nxt;
      power_fail_flag_n  <= !pfail_s;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_pf_flag;
    clk_en |=> (power_fail_flag_n == !$past(pfail_s));
  endproperty
  a_pf_flag: assert property (p_pf_flag)
    else $error("power fail flag does not follow comparator");

  property p_wd_expire;
    clk_en && wd_en && !kick_edge && wd_at_last |=> expired_r && !watchdog_expired_n;
  endproperty
  a_wd_expire: assert property (p_wd_expire)
    else $error("watchdog did not expire at end of period");

  property p_wd_float;
    clk_en && float_s |=> (wd_cnt_r == '0) && !expired_r;
  endproperty
  a_wd_float: assert property (p_wd_float)
    else $error("watchdog counts while kick input floats");

  property p_wd_edge;
    clk_en && kick_edge |=> (wd_cnt_r == '0) && !expired_r ##1 !expired_r;
  endproperty
  a_wd_edge: assert property (p_wd_edge)
    else $error("kick edge did not clear the watchdog");

  property p_wd_in_reset;
    clk_en && (state_r != RST_RUN) |=> (wd_cnt_r == '0) && !expired_r;
  endproperty
  a_wd_in_reset: assert property (p_wd_in_reset)
    else $error("watchdog active during reset");

  property p_wd_restart;
    clk_en && wd_en && kick_edge |=> clk_en && wd_en && !kick_edge |=> (wd_cnt_r == WCW'(1));
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("countdown not restarted from zero");

  property p_wd_hold;
    clk_en && expired_r && wd_en && !kick_edge |=> expired_r && !watchdog_expired_n;
  endproperty
  a_wd_hold: assert property (p_wd_hold)
    else $error("expired watchdog released without clear");

  property p_wd_supply;
    clk_en && HAS_WD && supply_low_s |=> !watchdog_expired_n;
  endproperty
  a_wd_supply: assert property (p_wd_supply)
    else $error("watchdog output high during supply low");

  property p_wd_release;
    clk_en && HAS_WD && !supply_low_s && (state_r != RST_RUN) |=> watchdog_expired_n;
  endproperty
  a_wd_release: assert property (p_wd_release)
    else $error("watchdog output not released after supply low");

  property p_no_wd_reset;
    clk_en && (state_r == RST_RUN) && !cause |=> (state_r == RST_RUN) && reset_out_n;
  endproperty
  a_no_wd_reset: assert property (p_no_wd_reset)
    else $error("reset asserted without supply low or manual reset");

  property p_rst_supply;
    clk_en && supply_low_s |=> (state_r == RST_HOLD) && !run_nxt;
  endproperty
  a_rst_supply: assert property (p_rst_supply)
    else $error("reset released during supply low");

  property p_rst_stretch;
    $rose(state_r == RST_RUN) |-> ($past(rs_cnt_r) == RST_LAST) && $past(state_r == RST_STRETCH);
  endproperty
  a_rst_stretch: assert property (p_rst_stretch)
    else $error("reset released before full stretch");

  property p_manual;
    clk_en && !manual_n_s |=> (state_r == RST_HOLD);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual reset low did not assert reset");

  property p_manual_restart;
    clk_en && (state_r == RST_STRETCH) && !manual_n_s |=> (state_r == RST_HOLD) && (rs_cnt_r == '0);
  endproperty
  a_manual_restart: assert property (p_manual_restart)
    else $error("manual reset bounce did not restart the stretch");

  property p_hold_leave;
    clk_en && (state_r == RST_HOLD) && !cause |=> (state_r == RST_STRETCH) && (rs_cnt_r == '0);
  endproperty
  a_hold_leave: assert property (p_hold_leave)
    else $error("stretch did not start when the cause cleared");

  property p_stretch_step;
    clk_en && (state_r == RST_STRETCH) && !cause && (rs_cnt_r != RST_LAST)
      |=> (state_r == RST_STRETCH) && (rs_cnt_r == $past(rs_cnt_r) + RCW'(1));
  endproperty
  a_stretch_step: assert property (p_stretch_step)
    else $error("stretch counter did not advance by one");

  property p_rst_low;
    clk_en && HAS_LOW && (state_nxt != RST_RUN) |=> !reset_out_n;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("active low reset not asserted outside normal running");

  property p_rst_high;
    clk_en && HAS_HI |=> (reset_out == (state_r != RST_RUN));
  endproperty
  a_rst_high: assert property (p_rst_high)
    else $error("active high reset does not mirror the sequencer");

  property p_no_wd_variant;
    !HAS_WD |-> watchdog_expired_n && (wd_cnt_r == '0);
  endproperty
  a_no_wd_variant: assert property (p_no_wd_variant)
    else $error("watchdog active in a variant without watchdog");

  property p_wd_cause_clear;
    clk_en && cause ##1 clk_en |=> (wd_cnt_r == '0) && !expired_r;
  endproperty
  a_wd_cause_clear: assert property (p_wd_cause_clear)
    else $error("reset cause did not clear the watchdog");

  property p_wd_step;
    clk_en && wd_en && !kick_edge && !wd_at_last |=> (wd_cnt_r == $past(wd_cnt_r) + WCW'(1));
  endproperty
  a_wd_step: assert property (p_wd_step)
    else $error("watchdog counter did not advance by one");

  property p_float_out;
    clk_en && HAS_WD && float_s && !supply_low_s |=> watchdog_expired_n;
  endproperty
  a_float_out: assert property (p_float_out)
    else $error("watchdog output low while kick input floats");

  property p_frozen;
    !clk_en |=> $stable(state_r) && $stable(wd_cnt_r) && $stable(reset_out_n)
      && $stable(watchdog_expired_n) && $stable(power_fail_flag_n);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while clock enable was low");

  generate
    if (OUT_SET == OUTSET_BOTH)
    begin : g_cmp
      property p_complement;
        reset_out == !reset_out_n;
      endproperty
      a_complement: assert property (p_complement)
        else $error("reset outputs not complementary");
    end
  endgenerate

  c_expire:  cover property ($rose(expired_r));
  c_release: cover property ($rose(state_r == RST_RUN));
  c_rebrown: cover property ((state_r == RST_STRETCH) ##1 (state_r == RST_HOLD));
  c_pf_low:  cover property ($fell(power_fail_flag_n));
  c_float:   cover property (float_s && (state_r == RST_RUN));

endmodule

//--- testbench/srw_proc_model.sv
// processor model: toggles the watchdog kick and counts shutdown requests
`timescale 1ns/1ps
module srw_proc_model
(
  // clock
  input  wire logic       clk_sys,
  // from the supervisor
  input  wire logic       reset_out_n,
  input  wire logic       power_fail_flag_n,
  // bench control
  input  wire logic       kick_en,
  input  wire logic [7:0] kick_gap,
  // to the supervisor and the bench
  output logic            watchdog_kick_in,
  output int              shutdown_count
);
  int   gap_cnt;
  logic flag_q;

  initial
  begin
    watchdog_kick_in = 1'h0;
    shutdown_count   = 0;
    gap_cnt          = 0;
    flag_q           = 1'h1;
  end

  // kicks only while running; a stopped kick holds its level
  always @(negedge clk_sys)
  begin
    if (kick_en && reset_out_n)
    begin
      if (gap_cnt >= int'(kick_gap))
      begin
        watchdog_kick_in <= ~watchdog_kick_in;
        gap_cnt          <= 0;
      end
      else
        gap_cnt <= gap_cnt + 1;
    end
    if (flag_q && !power_fail_flag_n)
      shutdown_count <= shutdown_count + 1;
    flag_q <= power_fail_flag_n;
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the supervisor with a cycle model
`timescale 1ns/1ps
module tb_top;
  import srw_pkg::*;
  localparam int RSTC = 16;
  localparam int WDC  = 32;
  logic clk_sys, rst, clk_en, supply_low_in, power_fail_sense_in, kick_float_in;
  logic manual_reset_n, kick_en;
  logic [7:0] kick_gap;
  logic watchdog_kick_in, rn, ro, wd, pf, b_rn, b_ro, b_wd, b_pf, h_rn, h_ro, h_wd, h_pf;
  int   shutdown_count, fail_count, tests_run, st, rc, wc, exp_sd;
  logic [4:0] s1, s2;
  logic kp, ex, cause, clr, e_rn, e_wd, e_pf;

  srw_top #(.OUT_SET(OUTSET_LOW_ONLY), .RST_CYCLES(RSTC), .WD_CYCLES(WDC)) uut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .supply_low_in(supply_low_in),
    .power_fail_sense_in(power_fail_sense_in), .kick_float_in(kick_float_in),
    .watchdog_kick_in(watchdog_kick_in), .manual_reset_n(manual_reset_n),
    .reset_out_n(rn), .reset_out(ro), .watchdog_expired_n(wd), .power_fail_flag_n(pf));
  srw_top #(.OUT_SET(OUTSET_BOTH), .RST_CYCLES(RSTC), .WD_CYCLES(WDC)) u_both (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .supply_low_in(supply_low_in),
    .power_fail_sense_in(power_fail_sense_in), .kick_float_in(kick_float_in),
    .watchdog_kick_in(watchdog_kick_in), .manual_reset_n(manual_reset_n),
    .reset_out_n(b_rn), .reset_out(b_ro), .watchdog_expired_n(b_wd),
    .power_fail_flag_n(b_pf));
  srw_top #(.OUT_SET(OUTSET_HIGH_ONLY), .RST_CYCLES(RSTC), .WD_CYCLES(WDC)) u_high (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .supply_low_in(supply_low_in),
    .power_fail_sense_in(power_fail_sense_in), .kick_float_in(kick_float_in),
    .watchdog_kick_in(watchdog_kick_in), .manual_reset_n(manual_reset_n),
    .reset_out_n(h_rn), .reset_out(h_ro), .watchdog_expired_n(h_wd),
    .power_fail_flag_n(h_pf));
  srw_proc_model u_proc (
    .clk_sys(clk_sys), .reset_out_n(rn), .power_fail_flag_n(pf), .kick_en(kick_en),
    .kick_gap(kick_gap), .watchdog_kick_in(watchdog_kick_in),
    .shutdown_count(shutdown_count));

  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // cycle model: two sync stages, hold/stretch/run sequencer, kick timer
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1 = 5'h10;
      s2 = 5'h10;
      {kp, ex, st, rc, wc} = 0;
      {e_rn, e_wd, e_pf} = 3'h3;
    end
    else if (clk_en)
    begin
      cause = s2[SYNC_SUPPLY] | ~s2[SYNC_MANUAL];
      clr   = (st != 2) | s2[SYNC_FLOAT] | (s2[SYNC_KICK] != kp);
      if (clr)
        {wc, ex} = 0;
      else if (wc == WDC - 1)
        ex = 1'h1;
      else
        wc++;
      e_wd = ~(ex | s2[SYNC_SUPPLY]);
      if (cause)
        {st, rc} = 0;
      else if (st == 0)
        st = 1;
      else if (st == 1 && rc == RSTC - 1)
        st = 2;
      else if (st == 1)
        rc++;
      e_rn = (st == 2);
      if (e_pf && s2[SYNC_PFAIL])
        exp_sd++;
      e_pf = ~s2[SYNC_PFAIL];
      kp   = s2[SYNC_KICK];
      s2   = s1;
      s1   = {manual_reset_n, watchdog_kick_in, kick_float_in, power_fail_sense_in,
              supply_low_in};
    end
  end

  task automatic chk(string nm, logic e, logic g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  always @(negedge clk_sys)
  begin
    if (!rst)
    begin
      chk("reset_out_n", e_rn, rn);
      chk("reset_out", 1'h0, ro);
      chk("watchdog_expired_n", e_wd, wd);
      chk("power_fail_flag_n", e_pf, pf);
      chk("both reset_out_n", e_rn, b_rn);
      chk("both reset_out", ~e_rn, b_ro);
      chk("both watchdog_expired_n", 1'h1, b_wd);
      chk("both power_fail_flag_n", e_pf, b_pf);
      chk("high reset_out_n", 1'h1, h_rn);
      chk("high reset_out", ~e_rn, h_ro);
      chk("high watchdog_expired_n", e_wd, h_wd);
      chk("high power_fail_flag_n", e_pf, h_pf);
    end
  end

  task automatic run(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #500000;
    fail_count++;
    close_out();
  end

  initial
  begin
    {fail_count, tests_run, exp_sd} = 0;
    {rst, clk_en, manual_reset_n} = 3'h7;
    {supply_low_in, power_fail_sense_in, kick_float_in, kick_en} = 4'h0;
    kick_gap = 8'h05;
    void'($urandom(52962));
    run(10);
    rst = 1'h0;
    run(30);
    // steady kicking, then starve the timer, then resume
    kick_en  = 1'h1;
    kick_gap = 8'($urandom % 12);
    run(300);
    kick_en = 1'h0;
    run(80);
    kick_en = 1'h1;
    run(50);
    // floating kick input
    kick_en       = 1'h0;
    kick_float_in = 1'h1;
    run(100);
    kick_float_in = 1'h0;
    kick_en       = 1'h1;
    run(60);
    // supply dip, second dip inside the stretch
    supply_low_in = 1'h1;
    run(20);
    supply_low_in = 1'h0;
    run(8);
    supply_low_in = 1'h1;
    run(3);
    supply_low_in = 1'h0;
    run(40);
    // bouncing pushbutton
    repeat (6)
    begin
      manual_reset_n = 1'($urandom % 2);
      run(1 + $urandom % 5);
    end
    manual_reset_n = 1'h1;
    run(40);
    repeat (400)
    begin
      clk_en              = ($urandom % 8) != 0;
      power_fail_sense_in = 1'($urandom % 2);
      supply_low_in       = ($urandom % 30) == 0;
      manual_reset_n      = ($urandom % 30) != 0;
      kick_float_in       = ($urandom % 20) == 0;
      kick_en             = ($urandom % 10) != 0;
      run(1 + $urandom % 8);
    end
    {clk_en, manual_reset_n} = 2'h3;
    {supply_low_in, kick_float_in} = 2'h0;
    rst = 1'h1;
    run(2);
    rst = 1'h0;
    run(40);
    chk("shutdown count", 1'h1, shutdown_count == exp_sd);
    close_out();
  end
endmodule
